// ==== fan_pwm_pkg.sv ====
package fan_pwm_pkg;

  // Register byte offsets on the 32-bit register bus.
  localparam logic [11:0] PRESCALE_OFFS = 12'h000;
  localparam logic [11:0] DUTY_OFFS = 12'h004;
  localparam logic [11:0] CTRL_OFFS = 12'h008;
  localparam logic [11:0] STATUS_OFFS = 12'h00C;

  // Field positions.
  localparam int CLK_SEL_BIT = 7;
  localparam int PRE_MSB = 6;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_INV_BIT = 1;
  localparam int STAT_PWM_BIT = 8;
  localparam int STAT_OUT_BIT = 9;

  // Reset values.
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [7:0] DUTY_RST = 8'hFF;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_INV_RST = 1'b0;

  // Duty extremes.
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [7:0] CNT_LAST = 8'hFF;

  // Rates in kHz: system clock and the two selectable source clocks.
  localparam int SYS_CLK_KHZ = 125000;
  localparam int FAST_SRC_KHZ = 24000;
  localparam int SLOW_SRC_KHZ = 200;
  localparam logic [17:0] ACC_MOD = 18'(SYS_CLK_KHZ);
  localparam logic [17:0] FAST_STEP = 18'(FAST_SRC_KHZ);
  localparam logic [17:0] SLOW_STEP = 18'(SLOW_SRC_KHZ);

  // Bus responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum {REG_PRESCALE, REG_DUTY, REG_CTRL, REG_STATUS, REG_NONE} reg_sel_t;

endpackage

// ==== pwm_clk_if.sv ====
`timescale 1ns/1ps
interface pwm_clk_if;
  logic clk_sel;
  logic [6:0] pre;
  logic run;
  logic tick;
  modport ctrl (output clk_sel, output pre, output run, input tick);
  modport div (input clk_sel, input pre, input run, output tick);
endinterface

// ==== pwm_prescaler.sv ====
`timescale 1ns/1ps
module pwm_prescaler (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  pwm_clk_if.div cfg // Source select, divider and counter tick.
);

  logic [16:0] acc_reg;
  logic [17:0] acc_sum;
  logic src_tick;
  logic [6:0] div_cnt_reg;

  // Phase accumulator makes a one-cycle pulse at the selected source rate.
  always_comb begin
    acc_sum = {1'b0, acc_reg} + (cfg.clk_sel ? fan_pwm_pkg::SLOW_STEP : fan_pwm_pkg::FAST_STEP);
    src_tick = cfg.run && (acc_sum >= fan_pwm_pkg::ACC_MOD);
  end

  // The accumulator keeps its residue so the average rate is exact.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      acc_reg <= 17'h00000;
    end else if (!cfg.run) begin
      acc_reg <= 17'h00000;
    end else if (src_tick) begin
      acc_reg <= 17'(acc_sum - fan_pwm_pkg::ACC_MOD);
    end else begin
      acc_reg <= acc_sum[16:0];
    end
  end

  // Divide the source pulses by the divider field plus one.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_cnt_reg <= 7'h00;
    end else if (!cfg.run) begin
      div_cnt_reg <= 7'h00;
    end else if (src_tick) begin
      div_cnt_reg <= (div_cnt_reg >= cfg.pre) ? 7'h00 : div_cnt_reg + 7'h01;
    end
  end

  // With a zero divider every source pulse steps the counter.
  assign cfg.tick = src_tick && (div_cnt_reg >= cfg.pre);

  sequence seq_fast_pulse;
    src_tick && !cfg.clk_sel;
  endsequence

  sequence seq_slow_pulse;
    src_tick && cfg.clk_sel && $stable(cfg.clk_sel);
  endsequence

  chk_fast_src_gap: assert property (@(posedge clk) disable iff (!nrst)
    seq_fast_pulse |=> !src_tick)
    else $error("fast source pulses came back to back");

  chk_slow_src_gap: assert property (@(posedge clk) disable iff (!nrst)
    seq_slow_pulse ##1 cfg.clk_sel |-> !src_tick[*8])
    else $error("slow source pulses came too close");

  chk_div_step: assert property (@(posedge clk) disable iff (!nrst)
    cfg.run && src_tick && (div_cnt_reg < cfg.pre) && $stable(cfg.pre)
      |=> div_cnt_reg == $past(div_cnt_reg) + 7'h01)
    else $error("divider count did not step");

  chk_div_bypass: assert property (@(posedge clk) disable iff (!nrst)
    cfg.pre == 7'h00 |-> cfg.tick == src_tick)
    else $error("zero divider did not pass source pulses");

endmodule

// ==== fan_pwm_speed_control.sv ====
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module fan_pwm_speed_control (
  input wire logic clk, // System clock, 125 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic [11:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [11:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic fan_drive_out // Fan power control pin.
);

  logic [7:0] fan_pwm_prescale_reg;
  logic [7:0] fan_pwm_duty_reg;
  logic enable_reg;
  logic output_invert_cfg_reg;
  logic [7:0] cnt_reg;
  logic pwm_reg;
  logic pwm_next;
  logic fan_out_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic wr_fire;
  fan_pwm_pkg::reg_sel_t wr_sel;
  fan_pwm_pkg::reg_sel_t rd_sel;

  pwm_clk_if clk_link ();

  // Maps a byte address onto a register, unknown addresses to none.
  function automatic fan_pwm_pkg::reg_sel_t decode(input logic [11:0] addr);
    case (addr)
      fan_pwm_pkg::PRESCALE_OFFS: decode = fan_pwm_pkg::REG_PRESCALE;
      fan_pwm_pkg::DUTY_OFFS: decode = fan_pwm_pkg::REG_DUTY;
      fan_pwm_pkg::CTRL_OFFS: decode = fan_pwm_pkg::REG_CTRL;
      fan_pwm_pkg::STATUS_OFFS: decode = fan_pwm_pkg::REG_STATUS;
      default: decode = fan_pwm_pkg::REG_NONE;
    endcase
  endfunction

  // Address and data are each held until both are present.
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready = !w_hold_reg && !bvalid_reg;
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign wr_sel = decode(awaddr_reg);
  assign rd_sel = decode(s_axi_araddr);
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  // Write address and data capture, in either order.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= 12'h000;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
    end
  end

  // Write response; unmapped or read-only addresses answer SLVERR.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= fan_pwm_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= (wr_sel == fan_pwm_pkg::REG_NONE || wr_sel == fan_pwm_pkg::REG_STATUS) ?
        fan_pwm_pkg::RESP_SLVERR : fan_pwm_pkg::RESP_OKAY;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Register writes; only byte lane 0 carries data.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fan_pwm_prescale_reg <= fan_pwm_pkg::PRESCALE_RST;
      fan_pwm_duty_reg <= fan_pwm_pkg::DUTY_RST;
      enable_reg <= fan_pwm_pkg::CTRL_EN_RST;
      output_invert_cfg_reg <= fan_pwm_pkg::CTRL_INV_RST;
    end else if (wr_fire && wstrb_reg[0]) begin
      case (wr_sel)
        fan_pwm_pkg::REG_PRESCALE: fan_pwm_prescale_reg <= wdata_reg[7:0];
        fan_pwm_pkg::REG_DUTY: fan_pwm_duty_reg <= wdata_reg[7:0];
        fan_pwm_pkg::REG_CTRL: begin
          enable_reg <= wdata_reg[fan_pwm_pkg::CTRL_EN_BIT];
          output_invert_cfg_reg <= wdata_reg[fan_pwm_pkg::CTRL_INV_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // Read channel; data registered one cycle after the address is taken.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= fan_pwm_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= fan_pwm_pkg::RESP_OKAY;
      rdata_reg <= 32'h00000000;
      case (rd_sel)
        fan_pwm_pkg::REG_PRESCALE: rdata_reg[7:0] <= fan_pwm_prescale_reg;
        fan_pwm_pkg::REG_DUTY: rdata_reg[7:0] <= fan_pwm_duty_reg;
        fan_pwm_pkg::REG_CTRL: begin
          rdata_reg[fan_pwm_pkg::CTRL_EN_BIT] <= enable_reg;
          rdata_reg[fan_pwm_pkg::CTRL_INV_BIT] <= output_invert_cfg_reg;
        end
        fan_pwm_pkg::REG_STATUS: begin
          rdata_reg[7:0] <= cnt_reg;
          rdata_reg[fan_pwm_pkg::STAT_PWM_BIT] <= pwm_reg;
          rdata_reg[fan_pwm_pkg::STAT_OUT_BIT] <= fan_out_reg;
        end
        default: rresp_reg <= fan_pwm_pkg::RESP_SLVERR;
      endcase
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // Divider settings go to the prescaler, which returns the counter step.
  assign clk_link.clk_sel = fan_pwm_prescale_reg[fan_pwm_pkg::CLK_SEL_BIT];
  assign clk_link.pre = fan_pwm_prescale_reg[fan_pwm_pkg::PRE_MSB:0];
  assign clk_link.run = enable_reg;

  pwm_prescaler u_prescaler (
    .clk(clk),
    .nrst(nrst),
    .cfg(clk_link.div)
  );

  // Free-running 8-bit counter; it rests at zero while the drive is off.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 8'h00;
    end else if (!enable_reg) begin
      cnt_reg <= 8'h00;
    end else if (clk_link.tick) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end

  // High while enabled and count is below duty; full duty never goes low while enabled.
  assign pwm_next = enable_reg &&
    ((cnt_reg < fan_pwm_duty_reg) || (fan_pwm_duty_reg == fan_pwm_pkg::DUTY_FULL));

  // Output stage, optionally inverted on the pin.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_reg <= 1'b0;
      fan_out_reg <= 1'b0;
    end else begin
      pwm_reg <= pwm_next;
      fan_out_reg <= pwm_next ^ output_invert_cfg_reg;
    end
  end

  assign fan_drive_out = fan_out_reg;

  sequence seq_wrap;
    clk_link.tick && cnt_reg == fan_pwm_pkg::CNT_LAST && enable_reg;
  endsequence

  chk_cnt_wraps: assert property (@(posedge clk) disable iff (!nrst)
    seq_wrap |=> cnt_reg == 8'h00)
    else $error("counter did not wrap to zero");

  chk_cnt_hold: assert property (@(posedge clk) disable iff (!nrst)
    enable_reg && !clk_link.tick ##1 enable_reg |-> $stable(cnt_reg))
    else $error("counter moved without a step");

  chk_duty_zero: assert property (@(posedge clk) disable iff (!nrst)
    fan_pwm_duty_reg == fan_pwm_pkg::DUTY_ZERO |=> !pwm_reg)
    else $error("zero duty gave a high level");

  chk_duty_full: assert property (@(posedge clk) disable iff (!nrst)
    enable_reg && fan_pwm_duty_reg == fan_pwm_pkg::DUTY_FULL |=> pwm_reg)
    else $error("full duty gave a low level");

  chk_pwm_compare: assert property (@(posedge clk) disable iff (!nrst)
    enable_reg && fan_pwm_duty_reg != fan_pwm_pkg::DUTY_FULL
      |=> pwm_reg == ($past(cnt_reg) < $past(fan_pwm_duty_reg)))
    else $error("pwm level disagrees with count and duty");

  chk_out_invert: assert property (@(posedge clk) disable iff (!nrst)
    ##1 fan_drive_out == (pwm_reg ^ $past(output_invert_cfg_reg)))
    else $error("fan pin does not follow pwm and invert");

  chk_reset_values: assert property (@(posedge clk)
    $rose(nrst) |-> fan_pwm_prescale_reg == fan_pwm_pkg::PRESCALE_RST &&
      fan_pwm_duty_reg == fan_pwm_pkg::DUTY_RST)
    else $error("registers not at reset values");

endmodule

// ==== fan_load_model.sv ====
`timescale 1ns/1ps
// Fan input that times the drive pin between rising edges.
module fan_load_model (
  input wire logic clk, // System clock.
  input wire logic nrst, // Reset, active low.
  input wire logic pin, // Fan drive pin.
  output int hi_len, // High cycles of the last full period.
  output int per_len, // Cycles of the last full period.
  output int rises // Rising edges seen.
);
  int hi_cnt;
  int per_cnt;
  logic pin_q;
  // A rising edge closes one period and opens the next; the fan only listens.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b0;
      hi_cnt <= 0;
      per_cnt <= 0;
      hi_len <= 0;
      per_len <= 0;
      rises <= 0;
    end else begin
      pin_q <= pin;
      if (pin && !pin_q) begin
        hi_len <= hi_cnt;
        per_len <= per_cnt;
        rises <= rises + 1;
        hi_cnt <= 1;
        per_cnt <= 1;
      end else begin
        per_cnt <= per_cnt + 1;
        hi_cnt <= hi_cnt + (pin ? 1 : 0);
      end
    end
  end
endmodule

// ==== fan_pwm_speed_control_bench.sv ====
`timescale 1ns/1ps
// Self-checking bench for the fan drive generator.
module fan_pwm_speed_control_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, pin;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic [7:0] c0;
  logic [7:0] duties [6] = '{8'h01, 8'hFE, 8'h80, 8'h01, 8'h01, 8'h01};
  int hi_len, per_len, rises, r0;
  int fail_count = 0;
  int checked = 0;

  // Free-running 125 MHz clock.
  always #4 clk = ~clk;

  fan_pwm_speed_control dut_u (.clk(clk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .fan_drive_out(pin));

  fan_load_model fan_u (.clk(clk), .nrst(nrst), .pin(pin), .hi_len(hi_len),
    .per_len(per_len), .rises(rises));

  // Compares one value and counts the outcome.
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Tolerance of two clocks for the source pulse jitter.
  function automatic bit near(input int a, input int b);
    return (a - b <= 2) && (b - a <= 2);
  endfunction

  // Clocks taken by a number of counter steps at a divider and source.
  function automatic int clks(input int steps, input int div, input bit slow);
    real k;
    k = real'(fan_pwm_pkg::SYS_CLK_KHZ) / (slow ? fan_pwm_pkg::SLOW_SRC_KHZ :
      fan_pwm_pkg::FAST_SRC_KHZ);
    return $rtoi(steps * div * k + 0.5);
  endfunction

  // One register write; address and data are released as each is taken.
  // Handshakes are read right at the edge, before the design updates.
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    resp = bresp;
  endtask

  // One register read into rd and resp; the word is taken at the answer edge.
  task automatic rd_reg(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask

  // Drive is switched off around every prescale change.
  task automatic set_pre(input logic [7:0] p, input logic inv);
    wr(fan_pwm_pkg::CTRL_OFFS, 32'h00000000, 4'hF);
    wr(fan_pwm_pkg::PRESCALE_OFFS, {24'h000000, p}, 4'hF);
    wr(fan_pwm_pkg::CTRL_OFFS, {30'h00000000, inv, 1'b1}, 4'hF);
  endtask

  // Times one full period after two fresh rising edges.
  task automatic measure(input int exp_hi, input int exp_per);
    int r;
    r = rises;
    while (rises < r + 2) @(posedge clk);
    #1;
    check("high time", 32'(near(hi_len, exp_hi)), 32'h1);
    check("period", 32'(near(per_len, exp_per)), 32'h1);
  endtask

  // Prints the verdict and ends the run.
  task automatic print_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence: reset state, bus errors, duty sweep, divider, inversion, slow source.
  initial begin
    void'($urandom(82462));
    for (int i = 3; i < 6; i++) duties[i] = 8'($urandom_range(254, 1));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(fan_pwm_pkg::PRESCALE_OFFS);
    check("prescale reset", rd, 32'h00000000);
    rd_reg(fan_pwm_pkg::DUTY_OFFS);
    check("duty reset", rd, 32'h000000FF);
    r0 = rises;
    repeat (2000) @(posedge clk);
    check("pin at full duty", {31'h0, pin}, 32'h1);
    check("edges at full duty", 32'(rises - r0), 32'h0);
    rd_reg(12'h010);
    check("unmapped read resp", {30'h0, resp}, {30'h0, fan_pwm_pkg::RESP_SLVERR});
    check("unmapped read data", rd, 32'h00000000);
    wr(fan_pwm_pkg::STATUS_OFFS, 32'h000000FF, 4'hF);
    check("status write resp", {30'h0, resp}, {30'h0, fan_pwm_pkg::RESP_SLVERR});
    wr(fan_pwm_pkg::DUTY_OFFS, 32'h00000012, 4'h0);
    rd_reg(fan_pwm_pkg::DUTY_OFFS);
    check("masked duty write", rd, 32'h000000FF);
    foreach (duties[i]) begin
      wr(fan_pwm_pkg::DUTY_OFFS, {24'h000000, duties[i]}, 4'hF);
      measure(clks(duties[i], 1, 0), clks(256, 1, 0));
    end
    wr(fan_pwm_pkg::DUTY_OFFS, 32'h00000000, 4'hF);
    repeat (1500) @(posedge clk);
    r0 = rises;
    repeat (3000) @(posedge clk);
    check("pin at zero duty", {31'h0, pin}, 32'h0);
    check("edges at zero duty", 32'(rises - r0), 32'h0);
    wr(fan_pwm_pkg::DUTY_OFFS, 32'h00000040, 4'hF);
    set_pre(8'h02, 1'b1);
    rd_reg(fan_pwm_pkg::PRESCALE_OFFS);
    check("prescale readback", rd, 32'h00000002);
    measure(clks(192, 3, 0), clks(256, 3, 0));
    set_pre(8'h80, 1'b0);
    rd_reg(fan_pwm_pkg::STATUS_OFFS);
    c0 = rd[7:0];
    repeat (6250) @(posedge clk);
    rd_reg(fan_pwm_pkg::STATUS_OFFS);
    c0 = rd[7:0] - c0;
    check("slow source steps", 32'(near(c0, 10)), 32'h1);
    print_verdict();
  end

  // The run needs about thirty-five thousand cycles; a hang is cut short well after that.
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    print_verdict();
  end
endmodule
